// ---- core/cal_cmd_core.sv ----
module cal_cmd_core
  import cal_cmd_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output wire logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output wire logic                   s_axi_wready,
  output logic      [1:0]             s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output wire logic                   s_axi_arready,
  output logic      [31:0]            s_axi_rdata,
  output logic      [1:0]             s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   frame_valid,
  input  wire cal_cmd_pkg::can_frame_t frame,
  output wire logic                   frame_ready,
  output logic                        save_req,
  output logic                        save_error_set,
  input  wire logic                   save_ack,
  output cal_cmd_pkg::sp_image_t      sp_image
);

  function automatic reg_sel_t reg_decode(input logic [7:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == ADDR_CTRL) begin
      s = SEL_CTRL;
    end else if (a == ADDR_PGN) begin
      s = SEL_PGN;
    end else if (a == ADDR_STATUS) begin
      s = SEL_STAT;
    end else if (a[7:4] == CAP_PAGE && a[1:0] == 2'b00) begin
      s = SEL_CAP;
    end else if (a[7:6] == SP_PAGE && a[1:0] == 2'b00) begin
      s = SEL_SP;
    end
    return s;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] sp_idx(input logic [1:0] inp,
                                        input logic       err,
                                        input logic       hi);
    return {inp, err, hi};
  endfunction

  function automatic logic fits(input logic signed [SP_W-1:0] v,
                                input logic signed [SP_W-1:0] lo,
                                input logic signed [SP_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // software state
  logic [3:0]             unit_lbs_r;
  logic [17:0]            pgn_r;
  logic [NUM_IN-1:0][MAG_W-1:0] cap_r;
  sp_image_t              sp_r;
  logic [7:0]             acc_cnt_r;
  logic [7:0]             rej_cnt_r;
  cmd_res_t               last_res_r;

  // frame decode
  wire logic [7:0]       code     = frame.data[5];
  wire logic [7:0]       opt      = frame.data[4];
  wire logic [7:0]       sign     = frame.data[3];
  wire logic [MAG_W-1:0] mag      = {frame.data[2], frame.data[1],
                                     frame.data[0]};
  wire logic             for_us   = frame_valid
                                    && frame.pgn == pgn_r;
  wire logic             len_ok   = frame.len == FRAME_LEN;
  wire logic             is_rset  = code == CMD_RANGE_SET;
  wire logic             is_eset  = code == CMD_ERR_SET;
  wire logic             is_rsave = code == CMD_RANGE_SAVE;
  wire logic             is_esave = code == CMD_ERR_SAVE;
  wire logic             set_hit  = for_us && len_ok && (is_rset || is_eset);
  // bytes after a save code are never looked at
  wire logic             save_hit = for_us && len_ok
                                    && (is_rsave || is_esave);
  wire logic             sign_ok  = sign == SIGN_POS || sign == SIGN_NEG;
  wire logic             sel_max  = opt[OPT_MAX_BIT];
  wire logic [3:0]       in_mask  = opt[3:0];
  wire logic [SP_W-1:0]  mag_ext  = {1'b0, mag};
  wire logic [SP_W-1:0]  value_c  = (sign == SIGN_NEG) ? -mag_ext
                                                       : mag_ext;

  logic [NUM_IN-1:0] fit_c;
  logic [NUM_IN-1:0] upd_c;

  always_comb begin
    logic signed [SP_W-1:0] cap_s;
    logic signed [SP_W-1:0] lo;
    logic signed [SP_W-1:0] hi;
    cap_s = '0;
    lo    = '0;
    hi    = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      cap_s = {1'b0, cap_r[i]};
      // each bound of the pair is capped by capacity and the other one
      if (sel_max) begin
        lo = sp_r[sp_idx(2'(i), is_eset, 1'b0)];
        hi = cap_s;
      end else begin
        lo = -cap_s;
        hi = sp_r[sp_idx(2'(i), is_eset, 1'b1)];
      end
      fit_c[i] = fits(value_c, lo, hi);
      upd_c[i] = set_hit && sign_ok && in_mask[i] && fit_c[i];
    end
  end

  wire logic set_clean = sign_ok && (in_mask != 4'h0)
                         && ((fit_c | ~in_mask) == 4'hF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_IN; i++) begin
        sp_r[sp_idx(2'(i), 1'b0, 1'b0)] <= SP_MIN_RST;
        sp_r[sp_idx(2'(i), 1'b0, 1'b1)] <= SP_MAX_RST;
        sp_r[sp_idx(2'(i), 1'b1, 1'b0)] <= SP_MIN_RST;
        sp_r[sp_idx(2'(i), 1'b1, 1'b1)] <= SP_MAX_RST;
      end
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (upd_c[i]) begin
          sp_r[sp_idx(2'(i), is_eset, sel_max)] <= value_c;
        end
      end
    end
  end

  // a new save that lands on the acknowledge cycle keeps the request up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      save_req       <= 1'b0;
      save_error_set <= 1'b0;
    end else begin
      save_req <= save_hit || (save_req && !save_ack);
      if (save_hit) begin
        save_error_set <= is_esave;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_cnt_r  <= 8'h00;
      rej_cnt_r  <= 8'h00;
      last_res_r <= RES_NONE;
    end else if (save_hit || (set_hit && set_clean)) begin
      acc_cnt_r  <= acc_cnt_r + 8'h01;
      last_res_r <= RES_APPLIED;
    end else if (set_hit && sign_ok) begin
      rej_cnt_r  <= rej_cnt_r + 8'h01;
      last_res_r <= RES_BOUNDS;
    end else if (for_us) begin
      rej_cnt_r  <= rej_cnt_r + 8'h01;
      last_res_r <= RES_IGNORED;
    end
  end

  // every frame is decided in the cycle it is offered
  assign frame_ready = 1'b1;
  assign sp_image    = sp_r;

  // write channel: address and data are held separately until both exist
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;

  wire logic        aw_hs   = s_axi_awvalid && s_axi_awready;
  wire logic        w_hs    = s_axi_wvalid && s_axi_wready;
  wire logic        do_wr   = (aw_held_r || aw_hs) && (w_held_r || w_hs);
  wire logic [7:0]  wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire logic [3:0]  wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire reg_sel_t    wr_sel  = reg_decode(wr_addr);
  wire logic [1:0]  wr_cap  = wr_addr[3:2];
  wire logic [31:0] cap_new = strb_merge({8'h00, cap_r[wr_cap]},
                                         wr_data, wr_strb);
  wire logic [31:0] ctrl_new = strb_merge({28'h000_0000, unit_lbs_r},
                                          wr_data, wr_strb);
  wire logic [31:0] pgn_new  = strb_merge({14'h0000, pgn_r}, wr_data,
                                          wr_strb);
  wire logic [MAG_W-1:0] cap_lim = unit_lbs_r[wr_cap]
                                   ? CAP_LIMIT_LB : CAP_LIMIT_KG;
  // upper byte set would mean negative or oversize
  wire logic        cap_ok  = cap_new[31:24] == 8'h00
                              && cap_new[23:0] <= cap_lim;
  wire logic        wr_ok   = wr_sel == SEL_CTRL || wr_sel == SEL_PGN
                              || (wr_sel == SEL_CAP && cap_ok);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      aw_held_r <= !do_wr && (aw_held_r || aw_hs);
      w_held_r  <= !do_wr && (w_held_r || w_hs);
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_lbs_r <= UNIT_RST;
      pgn_r      <= PGN_RST;
      cap_r      <= {NUM_IN{CAP_RST}};
    end else if (do_wr) begin
      if (wr_sel == SEL_CTRL) begin
        unit_lbs_r <= ctrl_new[3:0];
      end
      if (wr_sel == SEL_PGN) begin
        pgn_r <= pgn_new[17:0];
      end
      if (wr_sel == SEL_CAP && cap_ok) begin
        cap_r[wr_cap] <= cap_new[23:0];
      end
    end
  end

  // read channel: one word in flight, answered the cycle after address
  wire reg_sel_t   rd_sel = reg_decode(s_axi_araddr);
  wire logic [3:0] rd_sp  = s_axi_araddr[5:2];
  wire logic [1:0] rd_cap = s_axi_araddr[3:2];
  logic [31:0]     rd_word_c;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word_c = 32'h0000_0000;
    unique case (rd_sel)
      SEL_CTRL: rd_word_c = {28'h000_0000, unit_lbs_r};
      SEL_PGN:  rd_word_c = {14'h0000, pgn_r};
      SEL_STAT: rd_word_c = {12'h000, last_res_r, save_error_set,
                             save_req, rej_cnt_r, acc_cnt_r};
      SEL_CAP:  rd_word_c = {8'h00, cap_r[rd_cap]};
      SEL_SP:   rd_word_c = {{7{sp_r[rd_sp][SP_W-1]}}, sp_r[rd_sp]};
      SEL_NONE: rd_word_c = 32'h0000_0000;
      default:  rd_word_c = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word_c;
      s_axi_rresp  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- include/cal_cmd_pkg.sv ----
package cal_cmd_pkg;

  localparam int NUM_IN = 4;
  localparam int MAG_W  = 24;
  localparam int SP_W   = MAG_W + 1;

  // command codes in the first data byte
  localparam logic [7:0] CMD_RANGE_SET  = 8'hA5;
  localparam logic [7:0] CMD_RANGE_SAVE = 8'h5A;
  localparam logic [7:0] CMD_ERR_SET    = 8'hA6;
  localparam logic [7:0] CMD_ERR_SAVE   = 8'h6A;

  localparam logic [7:0] SIGN_POS = 8'h00;
  localparam logic [7:0] SIGN_NEG = 8'h01;

  localparam logic [3:0]  FRAME_LEN   = 4'h6;
  localparam logic [17:0] PGN_RST     = 18'h0_FFA5;
  localparam int          OPT_MAX_BIT = 4;

  // capacity ceilings, per weight unit
  localparam logic [MAG_W-1:0] CAP_LIMIT_KG = 24'h00_C350;
  localparam logic [MAG_W-1:0] CAP_LIMIT_LB = 24'h01_AE97;
  localparam logic [MAG_W-1:0] CAP_RST      = CAP_LIMIT_KG;
  localparam logic [3:0]       UNIT_RST     = 4'h0;
  localparam logic [SP_W-1:0]  SP_MIN_RST   = 25'h000_0000;
  localparam logic [SP_W-1:0]  SP_MAX_RST   = {1'b0, CAP_RST};

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PGN    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [3:0] CAP_PAGE    = 4'h1;
  localparam logic [1:0] SP_PAGE     = 2'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_PGN  = 3'b010,
    SEL_STAT = 3'b011,
    SEL_CAP  = 3'b100,
    SEL_SP   = 3'b101
  } reg_sel_t;

  typedef enum logic [1:0] {
    RES_NONE    = 2'b00,
    RES_APPLIED = 2'b01,
    RES_BOUNDS  = 2'b10,
    RES_IGNORED = 2'b11
  } cmd_res_t;

  typedef struct packed {
    logic [17:0]     pgn;
    logic [3:0]      len;
    logic [5:0][7:0] data;
  } can_frame_t;

  typedef logic [NUM_IN*4-1:0][SP_W-1:0] sp_image_t;

endpackage

// ---- test/cal_cmd_monitor.sv ----
module cal_cmd_monitor (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    frame_valid,
  input wire cal_cmd_pkg::can_frame_t frame,
  input wire logic                    frame_ready,
  input wire logic                    save_req,
  input wire logic                    save_error_set,
  input wire logic                    save_ack,
  input wire cal_cmd_pkg::sp_image_t  sp_image
);
  timeunit 1ns / 1ns;
  import cal_cmd_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // group match assumes the group register keeps its reset value
  wire [7:0] code   = frame.data[5];
  wire       hit    = frame_valid && frame.pgn == PGN_RST;
  wire       full   = hit && frame.len == FRAME_LEN;
  wire       set_c  = code == CMD_RANGE_SET || code == CMD_ERR_SET;
  wire       sgn_ok = frame.data[3] == SIGN_POS || frame.data[3] == SIGN_NEG;

  take_all_a: assert property (
    frame_ready) else $error("frame refused");
  range_save_a: assert property (
    full && code == CMD_RANGE_SAVE |=> save_req && !save_error_set)
    else $error("range save missed");
  err_save_a: assert property (
    full && code == CMD_ERR_SAVE |=> save_req && save_error_set)
    else $error("error save missed");
  save_hold_a: assert property (
    save_req && !save_ack |=> save_req) else $error("save dropped");
  bad_len_a: assert property (
    hit && frame.len != FRAME_LEN |=> $stable(sp_image))
    else $error("wrong length applied");
  bad_code_a: assert property (
    hit && !set_c |=> $stable(sp_image)) else $error("code applied");
  bad_sign_a: assert property (
    hit && !sgn_ok |=> $stable(sp_image)) else $error("bad sign applied");
  idle_hold_a: assert property (
    !hit |=> $stable(sp_image)) else $error("setpoint moved");

  cover property (full && code == CMD_RANGE_SET);
  cover property (full && code == CMD_ERR_SAVE);
  cover property (save_req && save_ack);
endmodule

bind cal_cmd_core cal_cmd_monitor u_cal_cmd_monitor (
  .aclk, .aresetn, .frame_valid, .frame, .frame_ready, .save_req,
  .save_error_set, .save_ack, .sp_image);

// ---- test/cal_tool_model.sv ----
module cal_tool_model (
  input  wire logic               aclk,
  input  wire logic               save_req,
  output logic                    save_ack,
  output logic                    frame_valid,
  output cal_cmd_pkg::can_frame_t frame
);
  timeunit 1ns / 1ns;
  import cal_cmd_pkg::*;
  int wait_n = 0;
  initial begin
    save_ack = 1'b0;
    frame_valid = 1'b0;
    frame = '0;
  end
  // flash writer is slow on purpose so the request has to wait for it
  always @(posedge aclk) begin
    wait_n <= (save_req && !save_ack) ? wait_n + 1 : 0;
    save_ack <= save_req && wait_n == 3;
  end
  task automatic send(input logic [7:0] code, opt, sgn,
                      input logic [23:0] mag, input logic [3:0] len);
    @(posedge aclk);
    frame_valid <= 1'b1;
    frame <= {PGN_RST, len, code, opt, sgn, mag};
    @(posedge aclk);
    frame_valid <= 1'b0;
    // an idle bus must not keep showing the last frame
    frame <= ~frame;
    @(negedge aclk);
  endtask
endmodule

// ---- test/can_range_error_calibration_cmd_bench.sv ----
module can_range_error_calibration_cmd_bench;
  timeunit 1ns / 1ns;
  import cal_cmd_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, frame_valid, frame_ready, save_ack;
  wire         save_req, save_error_set;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire can_frame_t frame;
  wire sp_image_t  sp_image;
  int          num_errors = 0, comparisons = 0;

  cal_cmd_core u_cal_cmd_core (.*);
  cal_tool_model u_cal_tool_model (.*);

  initial forever #4 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic stuck(input int n);
    if (n >= 40) begin
      chk("handshake", 32'h0000_0001, 32'h0000_0000);
      summarize();
    end
  endtask
  function automatic logic [SP_W-1:0] ng(input logic [MAG_W-1:0] m);
    return ~{1'b0, m} + 1'b1;
  endfunction
  task automatic sp(input int i, input logic [SP_W-1:0] e);
    chk("setpoint", 32'(e), 32'(sp_image[i]));
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    stuck(n);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk("resp", 32'(r), 32'(w ? s_axi_bresp : s_axi_rresp));
    if (!w) chk("rdata", d, s_axi_rdata);
  endtask

  task automatic t_defaults();
    sp(1, {1'b0, 24'h00_C350});
    xfer(1'b0, 8'h10, 32'h0000_C350, RESP_OKAY);
    xfer(1'b0, 8'h0C, 32'h0000_0000, RESP_SLVERR);
    xfer(1'b1, 8'h40, 32'h0000_0000, RESP_SLVERR);
  endtask
  task automatic t_range();
    u_cal_tool_model.send(CMD_RANGE_SET, 8'h04, SIGN_NEG, 24'h00_0032, 4'h6);
    sp(8, ng(24'h00_0032));
    u_cal_tool_model.send(CMD_RANGE_SET, 8'h14, SIGN_POS, 24'h01_ADB0, 4'h6);
    sp(9, {1'b0, 24'h00_C350});
    xfer(1'b1, ADDR_CTRL, 32'h0000_0004, RESP_OKAY);
    xfer(1'b1, 8'h18, 32'h0001_AE98, RESP_SLVERR);
    xfer(1'b1, 8'h18, 32'h0001_AE97, RESP_OKAY);
    u_cal_tool_model.send(CMD_RANGE_SET, 8'h14, SIGN_POS, 24'h01_ADB0, 4'h6);
    sp(9, {1'b0, 24'h01_ADB0});
    u_cal_tool_model.send(CMD_RANGE_SET, 8'h04, SIGN_NEG, 24'h01_AE98, 4'h6);
    sp(8, ng(24'h00_0032));
    u_cal_tool_model.send(CMD_RANGE_SET, 8'h04, SIGN_NEG, 24'h01_AE97, 4'h6);
    sp(8, ng(24'h01_AE97));
  endtask
  task automatic t_error();
    u_cal_tool_model.send(CMD_ERR_SET, 8'h08, SIGN_NEG, 24'h00_0DAC, 4'h6);
    sp(14, ng(24'h00_0DAC));
    u_cal_tool_model.send(CMD_ERR_SET, 8'h18, SIGN_POS, 24'h00_0DAC, 4'h6);
    sp(15, {1'b0, 24'h00_0DAC});
    u_cal_tool_model.send(CMD_ERR_SET, 8'h18, SIGN_NEG, 24'h00_0DAD, 4'h6);
    sp(15, {1'b0, 24'h00_0DAC});
    u_cal_tool_model.send(CMD_ERR_SET, 8'h08, SIGN_POS, 24'h00_0DAD, 4'h6);
    sp(14, ng(24'h00_0DAC));
    u_cal_tool_model.send(CMD_ERR_SET, 8'h03, SIGN_NEG, 24'h00_0001, 4'h6);
    sp(6, ng(24'h00_0001));
  endtask
  task automatic t_save();
    int n;
    u_cal_tool_model.send(CMD_RANGE_SAVE, 8'hA5, 8'h07, 24'hFF_FFFF, 4'h6);
    chk("save_req", 32'h0000_0001, 32'(save_req));
    chk("save_kind", 32'h0000_0000, 32'(save_error_set));
    for (n = 0; n < 40 && save_req !== 1'b0; n++) @(posedge aclk);
    stuck(n);
    u_cal_tool_model.send(CMD_ERR_SAVE, 8'h13, 8'h01, 24'h00_0001, 4'h6);
    chk("save_kind", 32'h0000_0001, 32'(save_error_set));
    u_cal_tool_model.send(CMD_ERR_SET, 8'h01, 8'h02, 24'h00_0005, 4'h6);
    sp(2, ng(24'h00_0001));
    u_cal_tool_model.send(CMD_ERR_SET, 8'h01, SIGN_POS, 24'h00_0005, 4'h5);
    sp(2, ng(24'h00_0001));
    u_cal_tool_model.send(8'hA7, 8'h01, SIGN_POS, 24'h00_0005, 4'h6);
    sp(2, ng(24'h00_0001));
  endtask
  task automatic t_status();
    u_cal_tool_model.send(CMD_RANGE_SET, 8'h00, SIGN_POS, 24'h00_0001, 4'h6);
    sp(0, SP_MIN_RST);
    xfer(1'b0, ADDR_PGN, 32'(PGN_RST), RESP_OKAY);
    xfer(1'b0, ADDR_STATUS, 32'h000A_0808, RESP_OKAY);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_range();
    t_error();
    t_save();
    t_status();
    summarize();
  end
endmodule
